// ==== src/scwd_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
module scwd_pin_sync
   import scwd_pkg::*;
(
   input  wire logic ref_clk_in, // System clock
   input  wire logic sys_rst_in, // Synchronous reset, active high
   input  wire logic pin_in,     // Raw pin level
   output logic      level_out   // Filtered level
);
   logic stage1;      // First stage, read only by stage2
   logic stage2;      // Second stage
   logic stage3;      // Third stage
   logic level;       // Accepted level
   logic next_level;  // Next accepted level

   ////////////////////////////////////////////////////////////////////////////////
   // Accept a change once stages two and three agree
   always_comb
   begin
      next_level = level;
      if (stage2 == stage3)
      begin
         next_level = stage3;
      end
   end

   // Stage registers; pin idles high
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         stage3 <= 1'b1;
         level  <= 1'b1;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level  <= next_level;
      end
   end

   assign level_out = level;
endmodule : scwd_pin_sync

// ==== src/scwd_pinsel_lock.sv ====
// Pin-select lock flag with unlock key sequence and one-way policy
module scwd_pinsel_lock
   import scwd_pkg::*;
(
   input  wire logic       ref_clk_in,          // System clock
   input  wire logic       sys_rst_in,          // Synchronous reset, active high
   input  wire logic       pinsel_one_way_lock, // One-way policy from config
   input  wire logic       key_wr_in,           // Unlock key write strobe
   input  wire logic [7:0] key_in,              // Unlock key value
   input  wire logic       lock_wr_in,          // Lock flag write strobe
   input  wire logic       lock_val_in,         // Requested flag value
   output logic            pinsel_lock_flag,    // Current lock flag
   output logic            armed_out            // Unlock sequence done
);
   typedef enum logic [1:0] {
      SCWD_LK_IDLE  = 2'b00, // Waiting for first key
      SCWD_LK_FIRST = 2'b01, // First key seen
      SCWD_LK_ARMED = 2'b10  // One flag write allowed
   } scwd_lock_st_t;

   scwd_lock_st_t state;      // Key sequence state
   scwd_lock_st_t next_state; // Next key state
   logic          next_flag;  // Next flag value

   ////////////////////////////////////////////////////////////////////////////////
   // Key sequence and flag update
   always_comb
   begin
      next_state = state;
      next_flag  = pinsel_lock_flag;
      case (state)
         SCWD_LK_IDLE:
         begin
            if (key_wr_in && key_in == SCWD_KEY_FIRST)
            begin
               next_state = SCWD_LK_FIRST;
            end
         end
         SCWD_LK_FIRST:
         begin
            if (key_wr_in)
            begin
               next_state = (key_in == SCWD_KEY_SECOND) ? SCWD_LK_ARMED : SCWD_LK_IDLE;
            end
            else if (lock_wr_in)
            begin
               next_state = SCWD_LK_IDLE; // Broken sequence
            end
         end
         SCWD_LK_ARMED:
         begin
            if (lock_wr_in)
            begin
               next_state = SCWD_LK_IDLE;
               // Once set under one-way policy the flag stays set
               if (!(pinsel_one_way_lock && pinsel_lock_flag))
               begin
                  next_flag = lock_val_in;
               end
            end
            else if (key_wr_in)
            begin
               next_state = SCWD_LK_IDLE; // Extra key cancels arming
            end
         end
         default:
         begin
            next_state = SCWD_LK_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         state            <= SCWD_LK_IDLE;
         pinsel_lock_flag <= 1'b0;
      end
      else
      begin
         state            <= next_state;
         pinsel_lock_flag <= next_flag;
      end
   end

   assign armed_out = (state == SCWD_LK_ARMED);
endmodule : scwd_pinsel_lock

// ==== src/scwd_pkg.sv ====
// Package: offsets, field positions, reset values and codes for the config word decoder
package scwd_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [23:0] SCWD_IDX_SUPERVISOR = 24'h300002; // Supervisor config word
   localparam logic [23:0] SCWD_IDX_WATCHDOG   = 24'h300004; // Watchdog config word
   localparam logic [23:0] SCWD_IDX_CTRL       = 24'h000010; // Software enable bits
   localparam logic [23:0] SCWD_IDX_LOCK       = 24'h000011; // Pin-select lock flag
   localparam logic [23:0] SCWD_IDX_UNLOCK     = 24'h000012; // Unlock key entry
   localparam logic [23:0] SCWD_IDX_STATUS     = 24'h000013; // Decoded state
   localparam int          SCWD_ADDR_W         = 26;         // Byte address width
   ////////////////////////////////////////////////////////////////////////////////
   // Supervisor word field positions
   localparam int SCWD_SUP_EXT_INSTR   = 15; // Extension disable
   localparam int SCWD_SUP_DEBUG       = 13; // Debugger disable
   localparam int SCWD_SUP_STACK_RST   = 12; // Stack fault reset enable
   localparam int SCWD_SUP_ONE_WAY     = 11; // One-way lock policy
   localparam int SCWD_SUP_ZERO_CROSS  = 10; // Zero-cross disable
   localparam int SCWD_SUP_LEVEL_LO    = 8;  // Brown-out level low bit
   localparam int SCWD_SUP_MODE_LO     = 6;  // Brown-out mode low bit
   localparam int SCWD_SUP_LP_BROWNOUT = 5;  // Low-power brown-out off
   localparam int SCWD_SUP_POWERUP     = 1;  // Power-up timer off
   localparam int SCWD_SUP_MASTER_CLEAR_PIN    = 0;  // Master clear pin enable
   localparam logic [15:0] SCWD_SUP_IMPL_MASK = 16'hbfe3; // Implemented bits
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog word field positions
   localparam int SCWD_WDT_CLK_LO    = 11; // Clock select low bit
   localparam int SCWD_WDT_WINDOW_LO = 8;  // Window select low bit
   localparam int SCWD_WDT_MODE_LO   = 5;  // Mode low bit
   localparam int SCWD_WDT_PERIOD_LO = 0;  // Period select low bit
   localparam logic [15:0] SCWD_WDT_IMPL_MASK = 16'h3f7f; // Implemented bits
   ////////////////////////////////////////////////////////////////////////////////
   // Control and status bit positions
   localparam int SCWD_CTRL_ZC_SW  = 0; // Zero-cross software enable
   localparam int SCWD_CTRL_BO_SW  = 1; // Brown-out software enable
   localparam int SCWD_CTRL_WDT_SW = 2; // Watchdog software enable
   localparam int SCWD_CTRL_CLK_LO = 3; // Software watchdog clock, two bits
   localparam logic [15:0] SCWD_CTRL_MASK  = 16'h001f; // Writable control bits
   localparam logic [15:0] SCWD_CTRL_RESET = 16'h0000; // Control after reset
   localparam int SCWD_STAT_STACK_SEEN = 4; // Sticky stack fault bit
   ////////////////////////////////////////////////////////////////////////////////
   // Unlock keys
   localparam logic [7:0] SCWD_KEY_FIRST  = 8'h55; // First unlock key
   localparam logic [7:0] SCWD_KEY_SECOND = 8'haa; // Second unlock key
   ////////////////////////////////////////////////////////////////////////////////
   // Codes
   typedef enum logic [1:0] {
      SCWD_LVL_2V85 = 2'b00, // 2.85 V trip
      SCWD_LVL_2V70 = 2'b01, // 2.7 V trip
      SCWD_LVL_2V45 = 2'b10, // 2.45 V trip
      SCWD_LVL_1V90 = 2'b11  // 1.90 V trip
   } scwd_level_t;
   typedef enum logic [1:0] {
      SCWD_MODE_OFF    = 2'b00, // Disabled
      SCWD_MODE_SW     = 2'b01, // Software bit decides
      SCWD_MODE_AWAKE  = 2'b10, // On while awake
      SCWD_MODE_ALWAYS = 2'b11  // Always on
   } scwd_mode_t;
   typedef enum logic [1:0] {
      SCWD_CLK_LF31_0 = 2'b00, // 31.0 kHz clock
      SCWD_CLK_MF31_2 = 2'b01, // 31.25 kHz clock
      SCWD_CLK_NONE   = 2'b10  // Watchdog off, no clock
   } scwd_clk_t;
   localparam logic [2:0] SCWD_WCLK_LF = 3'h0; // Config code for 31.0 kHz
   localparam logic [2:0] SCWD_WCLK_MF = 3'h1; // Config code for 31.25 kHz
   localparam logic [2:0] SCWD_WCLK_SW = 3'h7; // Config code for software choice
endpackage : scwd_pkg

// ==== src/scwd_top.sv ====
// Supervisor and watchdog config word decoder with register port
// Notes on behaviour
// - Extension bit one selects legacy instruction set
// - Debug bit zero enables background debugger
// - Stack fault resets only when enabled
// - One-way policy: lock flag set once
// - Zero-cross bit one: off until software enables it and the peripheral disable is low; bit zero: always on
// - Level field selects brown-out trip voltage
// - Brown-out mode: always, awake, software, off
// - Low-power brown-out enabled when bit zero
// - Power-up timer enabled when bit zero
// - Low-voltage programming forces master clear pin
// - Watchdog mode: always, awake, software, off
// - Watchdog clock select, reserved codes default
//
// Our own choice: the strobed register port.
module scwd_top
   import scwd_pkg::*;
(
   input  wire logic                   ref_clk_in,             // System clock
   input  wire logic                   sys_rst_in,             // Sync reset, active high
   input  wire logic [15:0]            nvm_supervisor_word_in, // Stored supervisor word
   input  wire logic [15:0]            nvm_watchdog_word_in,   // Stored watchdog word
   input  wire logic                   low_voltage_variant_in, // Variant strap
   input  wire logic                   low_voltage_prog_en_in, // Low-voltage programming
   input  wire logic                   sleep_in,               // Core in Sleep
   input  wire logic                   stack_overflow_in,      // Stack overflow pulse
   input  wire logic                   stack_underflow_in,     // Stack underflow pulse
   input  wire logic                   zero_cross_periph_off_in, // Peripheral disable
   input  wire logic                   shared_reset_pin_in,    // Shared pin, low active
   input  wire logic [SCWD_ADDR_W-1:0] addr_in,                // Byte address
   input  wire logic [15:0]            wr_data_in,             // Write data
   input  wire logic                   wr_in,                  // Write strobe
   input  wire logic                   rd_in,                  // Read strobe
   output logic      [15:0]            rd_data_out,            // Read data, next cycle
   output logic                        ext_instr_disable_out,  // Legacy instruction set
   output logic                        debugger_en_out,        // Debugger enabled
   output logic                        stack_fault_reset_out,  // Reset request pulse
   output logic                        pinsel_lock_flag_out,   // Pin-select locked
   output logic                        pinsel_write_ok_out,    // Pin-select writable
   output logic                        zero_cross_en_out,      // Detector on
   output scwd_level_t                 brownout_level_out,     // Trip level code
   output logic                        brownout_active_out,    // Brown-out armed
   output logic                        lowpower_brownout_en_out, // Low-power armed
   output logic                        powerup_timer_en_out,   // Power-up timer on
   output logic                        master_clear_pin_en_out, // Pin is master clear
   output logic                        master_clear_out,       // Master clear reset
   output logic                        port_pin_data_out,      // Pin as port input
   output logic                        watchdog_active_out,    // Watchdog running
   output scwd_clk_t                   watchdog_clock_out,     // Watchdog clock
   output logic      [2:0]             watchdog_window_sel_out, // Window setting
   output logic      [4:0]             watchdog_period_sel_out  // Period setting
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0] sup_word;        // Captured supervisor word
   logic [15:0] wdt_word;        // Captured watchdog word
   logic        lv_variant;      // Captured variant strap
   logic [15:0] ctrl;            // Software control bits
   logic [15:0] next_ctrl;       // Next control
   logic        stack_seen;      // Sticky stack fault
   logic        next_stack_seen; // Next sticky stack fault
   logic [15:0] rd_data;         // Registered read data
   logic [15:0] next_rd_data;    // Next read data
   logic        fault_rst;       // Registered reset request
   logic        next_fault_rst;  // Next reset request
   logic        pin_level;       // Filtered shared pin
   logic        port_data;       // Registered port data
   logic        next_port_data;  // Next port data
   logic        master_clear_reset;      // Registered master clear
   logic        next_master_clear_reset; // Next master clear
   logic        lock_flag;       // Pin-select lock flag
   logic        lock_armed;      // Unlock sequence done
   logic        key_wr;          // Unlock key write
   logic        lock_wr;         // Lock flag write
   logic        stack_fault;     // Any stack fault this cycle
   logic        master_clear_func;       // Pin acts as master clear
   scwd_mode_t  bo_mode;         // Brown-out mode field
   scwd_mode_t  wdt_mode;        // Watchdog mode field
   logic [2:0]  wdt_clk_code;    // Watchdog clock field
   logic        bo_active;       // Brown-out armed
   logic        wdt_active;      // Watchdog running
   scwd_clk_t   wdt_clk;         // Decoded watchdog clock
   scwd_level_t bo_level;        // Decoded trip level

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   // Word index match for a byte address
   function automatic logic scwd_hit(input logic [SCWD_ADDR_W-1:0] a,
                                     input logic [23:0] idx);
      scwd_hit = (a == {idx, 2'b00});
   endfunction : scwd_hit

   // Mode field to enable under Sleep and software bit
   function automatic logic scwd_mode_on(input scwd_mode_t m, input logic slp,
                                         input logic sw);
      case (m)
         SCWD_MODE_ALWAYS: scwd_mode_on = 1'b1;  // Software bit ignored
         SCWD_MODE_AWAKE:  scwd_mode_on = !slp;  // Off in Sleep
         SCWD_MODE_SW:     scwd_mode_on = sw;    // Software decides
         default:          scwd_mode_on = 1'b0;  // Disabled
      endcase
   endfunction : scwd_mode_on

   ////////////////////////////////////////////////////////////////////////////////
   // Capture config words only while reset is held
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         sup_word   <= nvm_supervisor_word_in & SCWD_SUP_IMPL_MASK;
         wdt_word   <= nvm_watchdog_word_in & SCWD_WDT_IMPL_MASK;
         lv_variant <= low_voltage_variant_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Static field decode
   assign bo_mode      = scwd_mode_t'(sup_word[SCWD_SUP_MODE_LO +: 2]);
   assign wdt_mode     = scwd_mode_t'(wdt_word[SCWD_WDT_MODE_LO +: 2]);
   assign wdt_clk_code = wdt_word[SCWD_WDT_CLK_LO +: 3];
   assign master_clear_func    = low_voltage_prog_en_in | sup_word[SCWD_SUP_MASTER_CLEAR_PIN];
   assign stack_fault  = stack_overflow_in | stack_underflow_in;

   // Brown-out trip level per variant
   always_comb
   begin
      case (sup_word[SCWD_SUP_LEVEL_LO +: 2])
         2'b00:   bo_level = SCWD_LVL_2V85;
         2'b01:   bo_level = SCWD_LVL_2V70;
         2'b10:   bo_level = SCWD_LVL_2V45;
         default: bo_level = lv_variant ? SCWD_LVL_1V90 : SCWD_LVL_2V45;
      endcase
   end

   // Brown-out and watchdog enables
   assign bo_active  = scwd_mode_on(bo_mode, sleep_in, ctrl[SCWD_CTRL_BO_SW]);
   assign wdt_active = scwd_mode_on(wdt_mode, sleep_in, ctrl[SCWD_CTRL_WDT_SW]);

   // Watchdog clock source
   always_comb
   begin
      if (wdt_mode == SCWD_MODE_OFF)
      begin
         wdt_clk = SCWD_CLK_NONE;
      end
      else if (wdt_clk_code == SCWD_WCLK_MF)
      begin
         wdt_clk = SCWD_CLK_MF31_2;
      end
      else if (wdt_clk_code == SCWD_WCLK_SW)
      begin
         // Software pick; reserved software code falls to 31.0 kHz
         wdt_clk = (ctrl[SCWD_CTRL_CLK_LO +: 2] == 2'b01) ? SCWD_CLK_MF31_2
                                                           : SCWD_CLK_LF31_0;
      end
      else
      begin
         wdt_clk = SCWD_CLK_LF31_0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register port strobes
   assign key_wr  = wr_in && scwd_hit(addr_in, SCWD_IDX_UNLOCK);
   assign lock_wr = wr_in && scwd_hit(addr_in, SCWD_IDX_LOCK);

   // Control writes, sticky fault, read mux; config word writes are ignored
   always_comb
   begin
      next_ctrl       = ctrl;
      next_stack_seen = stack_seen;
      next_rd_data    = 16'h0000;
      if (wr_in && scwd_hit(addr_in, SCWD_IDX_CTRL))
      begin
         next_ctrl = wr_data_in & SCWD_CTRL_MASK;
      end
      if (wr_in && scwd_hit(addr_in, SCWD_IDX_STATUS) && wr_data_in[SCWD_STAT_STACK_SEEN])
      begin
         next_stack_seen = 1'b0; // Write one to clear
      end
      if (stack_fault)
      begin
         next_stack_seen = 1'b1; // Set wins over clear
      end
      if (rd_in)
      begin
         if (scwd_hit(addr_in, SCWD_IDX_SUPERVISOR))
         begin
            next_rd_data = sup_word;
         end
         else if (scwd_hit(addr_in, SCWD_IDX_WATCHDOG))
         begin
            next_rd_data = wdt_word;
         end
         else if (scwd_hit(addr_in, SCWD_IDX_CTRL))
         begin
            next_rd_data = ctrl;
         end
         else if (scwd_hit(addr_in, SCWD_IDX_LOCK))
         begin
            next_rd_data = {15'h0000, lock_flag};
         end
         else if (scwd_hit(addr_in, SCWD_IDX_STATUS))
         begin
            next_rd_data = {11'h000, stack_seen, wdt_active, bo_active,
                            zero_cross_en_out, lock_armed};
         end
      end
   end

   // Stack fault reset request and shared pin function
   always_comb
   begin
      next_fault_rst  = stack_fault && sup_word[SCWD_SUP_STACK_RST];
      next_master_clear_reset = master_clear_func && !pin_level;
      next_port_data  = master_clear_func ? 1'b0 : pin_level;
   end

   // Runtime registers
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         ctrl       <= SCWD_CTRL_RESET;
         stack_seen <= 1'b0;
         rd_data    <= 16'h0000;
         fault_rst  <= 1'b0;
         master_clear_reset <= 1'b0;
         port_data  <= 1'b0;
      end
      else
      begin
         ctrl       <= next_ctrl;
         stack_seen <= next_stack_seen;
         rd_data    <= next_rd_data;
         fault_rst  <= next_fault_rst;
         master_clear_reset <= next_master_clear_reset;
         port_data  <= next_port_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Submodules
   scwd_pin_sync u_pin_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .pin_in     (shared_reset_pin_in),
      .level_out  (pin_level)
   );

   scwd_pinsel_lock u_lock (
      .ref_clk_in          (ref_clk_in),
      .sys_rst_in          (sys_rst_in),
      .pinsel_one_way_lock (sup_word[SCWD_SUP_ONE_WAY]),
      .key_wr_in           (key_wr),
      .key_in              (wr_data_in[7:0]),
      .lock_wr_in          (lock_wr),
      .lock_val_in         (wr_data_in[0]),
      .pinsel_lock_flag    (lock_flag),
      .armed_out           (lock_armed)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign rd_data_out              = rd_data;
   assign ext_instr_disable_out    = sup_word[SCWD_SUP_EXT_INSTR];
   assign debugger_en_out          = !sup_word[SCWD_SUP_DEBUG];
   assign stack_fault_reset_out    = fault_rst;
   assign pinsel_lock_flag_out     = lock_flag;
   assign pinsel_write_ok_out      = !lock_flag;
   assign zero_cross_en_out        = sup_word[SCWD_SUP_ZERO_CROSS]
                                     ? (ctrl[SCWD_CTRL_ZC_SW] && !zero_cross_periph_off_in)
                                     : 1'b1;
   assign brownout_level_out       = bo_level;
   assign brownout_active_out      = bo_active;
   assign lowpower_brownout_en_out = !sup_word[SCWD_SUP_LP_BROWNOUT];
   assign powerup_timer_en_out     = !sup_word[SCWD_SUP_POWERUP];
   assign master_clear_pin_en_out  = master_clear_func;
   assign master_clear_out         = master_clear_reset;
   assign port_pin_data_out        = port_data;
   assign watchdog_active_out      = wdt_active;
   assign watchdog_clock_out       = wdt_clk;
   assign watchdog_window_sel_out  = wdt_word[SCWD_WDT_WINDOW_LO +: 3];
   assign watchdog_period_sel_out  = wdt_word[SCWD_WDT_PERIOD_LO +: 5];
endmodule : scwd_top

// ==== tb/scwd_asserts.sv ====
// Checker for the config word decoder
module scwd_asserts
   import scwd_pkg::*;
(
   input wire logic        ref_clk_in,               // Clock
   input wire logic        sys_rst_in,               // Reset
   input wire logic [15:0] nvm_supervisor_word_in,   // Stored word
   input wire logic        low_voltage_prog_en_in,   // LV programming
   input wire logic        sleep_in,                 // Sleep
   input wire logic        stack_overflow_in,        // Overflow
   input wire logic        stack_underflow_in,       // Underflow
   input wire logic        ext_instr_disable_out,    // Legacy set
   input wire logic        debugger_en_out,          // Debugger
   input wire logic        stack_fault_reset_out,    // Fault reset
   input wire logic        pinsel_lock_flag_out,     // Lock flag
   input wire logic        zero_cross_en_out,        // Detector on
   input wire logic        brownout_active_out,      // Brown-out on
   input wire logic        lowpower_brownout_en_out, // Low-power on
   input wire logic        master_clear_pin_en_out   // Pin is reset
);
   timeunit 1ns;
   timeprecision 1ns;
////////////////////////////////////////////////////////////////////////////////
   logic [15:0] sup_q;    // Word captured in reset
   logic [15:0] next_sup; // Next captured word
   // Capture while reset is high
   always_comb next_sup = sys_rst_in ? nvm_supervisor_word_in : sup_q;
   always_ff @(posedge ref_clk_in) sup_q <= next_sup;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_ext; ext_instr_disable_out == sup_q[15]; endproperty
   a_ext: assert property (p_ext) else $error("ext mismatch");
   property p_dbg; debugger_en_out != sup_q[13]; endproperty
   a_dbg: assert property (p_dbg) else $error("dbg mismatch");
   property p_stk; stack_overflow_in || stack_underflow_in |=> stack_fault_reset_out == sup_q[12];
   endproperty
   a_stk: assert property (p_stk) else $error("stack mismatch");
   property p_lock; sup_q[11] && pinsel_lock_flag_out |=> pinsel_lock_flag_out; endproperty
   a_lock: assert property (p_lock) else $error("lock cleared");
   property p_zc; !sup_q[10] |-> zero_cross_en_out; endproperty
   a_zc: assert property (p_zc) else $error("zc off");
   property p_bo; sup_q[7:6] != 2'b01 |-> brownout_active_out == (sup_q[7] && (sup_q[6] || !sleep_in));
   endproperty
   a_bo: assert property (p_bo) else $error("bo mismatch");
   property p_lp; lowpower_brownout_en_out != sup_q[5]; endproperty
   a_lp: assert property (p_lp) else $error("lp mismatch");
   property p_mc; master_clear_pin_en_out == (low_voltage_prog_en_in || sup_q[0]); endproperty
   a_mc: assert property (p_mc) else $error("mc mismatch");
   c_stk: cover property (stack_fault_reset_out);
   c_lock: cover property (pinsel_lock_flag_out);
   c_slp: cover property (sleep_in && sup_q[7:6] == 2'b10);
endmodule : scwd_asserts
bind scwd_top scwd_asserts u_chk (.*);

// ==== tb/supervisor_config_word_decode_tb.sv ====
// Testbench for the config word decoder
module supervisor_config_word_decode_tb import scwd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_in = 0, sys_rst_in = 1, low_voltage_variant_in = 0, low_voltage_prog_en_in = 0;
   logic sleep_in = 0, stack_overflow_in = 0, stack_underflow_in = 0, wr_in = 0, rd_in = 0;
   logic zero_cross_periph_off_in = 0, shared_reset_pin_in = 1;
   logic [15:0] nvm_supervisor_word_in = 0, nvm_watchdog_word_in = 0, wr_data_in = 0, rd_data_out;
   logic [SCWD_ADDR_W-1:0] addr_in = 0;
   logic ext_instr_disable_out, debugger_en_out, stack_fault_reset_out, pinsel_lock_flag_out;
   logic pinsel_write_ok_out, zero_cross_en_out, brownout_active_out, lowpower_brownout_en_out;
   logic powerup_timer_en_out, master_clear_pin_en_out, master_clear_out, port_pin_data_out;
   logic watchdog_active_out;
   scwd_level_t brownout_level_out;
   scwd_clk_t watchdog_clock_out;
   logic [2:0] watchdog_window_sel_out;
   logic [4:0] watchdog_period_sel_out;
   logic [15:0] sup, wdt;
   logic [2:0] b;
   int fail_count = 0, n_tests = 0;
   always #5 ref_clk_in = ~ref_clk_in;
   scwd_top dut (.*);
////////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin fail_count++; $display("[ERR] %s expected %h seen %h", nm, e, g); end
   endtask : chk
   task wr(input logic [23:0] ix, input logic [15:0] d);
      @(posedge ref_clk_in); addr_in <= {ix, 2'b00}; wr_data_in <= d; wr_in <= 1;
      @(posedge ref_clk_in); wr_in <= 0; #1;
   endtask : wr
   task rd(input logic [23:0] ix, input logic [15:0] e, input string nm);
      @(posedge ref_clk_in); addr_in <= {ix, 2'b00}; rd_in <= 1;
      @(posedge ref_clk_in); rd_in <= 0; #1 chk(nm, {8'h00, e}, {8'h00, rd_data_out});
   endtask : rd
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
////////////////////////////////////////////////////////////////////////////////
   // Watchdog against hangs
   initial begin #40000; fail_count++; stop_test(); end
   // One reset per config, then live tests
   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         b = i[2:0];
         sup = {b[0], 1'b0, b[1], b[2], b[0], b[0], b[1:0], b[1:0], ~b[0], 3'h0, b[1], b[2]};
         wdt = {2'h0, b + 3'h2, b, 1'b0, b[1:0], b, 2'h3};
         @(posedge ref_clk_in); sys_rst_in <= 1; nvm_supervisor_word_in <= sup;
         nvm_watchdog_word_in <= wdt; low_voltage_variant_in <= b[2];
         low_voltage_prog_en_in <= b[1]; sleep_in <= b[2];
         repeat (5) @(posedge ref_clk_in);
         sys_rst_in <= 0; nvm_supervisor_word_in <= ~sup; nvm_watchdog_word_in <= ~wdt;
         @(posedge ref_clk_in); #1;
         chk("decode", {sup[15], !sup[13], !sup[10], (sup[9:8] == 2'h3 && !b[2]) ? 2'h2 : sup[9:8],
            sup[7:6] == 2'h3 || (sup[7:6] == 2'h2 && !b[2]), !sup[5], !sup[1], b[1] | sup[0],
            wdt[6:5] == 2'h3 || (wdt[6:5] == 2'h2 && !b[2]),
            wdt[6:5] == 2'h0 ? 2'h2 : {1'b0, wdt[13:11] == 3'h1}, wdt[10:8], wdt[4:0]},
            {ext_instr_disable_out, debugger_en_out, zero_cross_en_out, brownout_level_out,
            brownout_active_out, lowpower_brownout_en_out, powerup_timer_en_out,
            master_clear_pin_en_out, watchdog_active_out, watchdog_clock_out,
            watchdog_window_sel_out, watchdog_period_sel_out});
         rd(SCWD_IDX_SUPERVISOR, sup & SCWD_SUP_IMPL_MASK, "sup word");
         rd(SCWD_IDX_WATCHDOG, wdt & SCWD_WDT_IMPL_MASK, "wdt word");
         $display("config test %0d done", i);
      end
      wr(SCWD_IDX_CTRL, 16'h0001);
      chk("zc sw", 24'h1, {23'h0, zero_cross_en_out});
      @(posedge ref_clk_in); zero_cross_periph_off_in <= 1; shared_reset_pin_in <= 0; #1;
      chk("zc off", 24'h0, {23'h0, zero_cross_en_out});
      @(posedge ref_clk_in); stack_underflow_in <= 1;
      @(posedge ref_clk_in); stack_underflow_in <= 0; #1;
      chk("stack rst", 24'h1, {23'h0, stack_fault_reset_out});
      wr(SCWD_IDX_UNLOCK, 16'h0055); wr(SCWD_IDX_UNLOCK, 16'h00aa); wr(SCWD_IDX_LOCK, 16'h0001);
      chk("lock set", 24'h2, {22'h0, pinsel_lock_flag_out, pinsel_write_ok_out});
      chk("master_clear", 24'h2, {22'h0, master_clear_out, port_pin_data_out});
      wr(SCWD_IDX_UNLOCK, 16'h0055); wr(SCWD_IDX_UNLOCK, 16'h00aa); wr(SCWD_IDX_LOCK, 16'h0000);
      chk("lock kept", 24'h2, {22'h0, pinsel_lock_flag_out, pinsel_write_ok_out});
      rd(24'h000020, 16'h0000, "unmapped");
      $display("live tests done");
      stop_test();
   end
endmodule : supervisor_config_word_decode_tb
